// >>> gauge_link_defines.vh
// constants for the single-wire gauge host controller
// assumes a 10 MHz system clock; included by its bare name
`ifndef GAUGE_LINK_DEFINES_VH
`define GAUGE_LINK_DEFINES_VH

// ****************************************
// clock and line timing
// ****************************************
`define CLK_FREQ_KHZ        10000
// least times round up to whole cycles
`define BIT_CYCLE_US        200
`define BIT_CYCLE_CYC       ((`BIT_CYCLE_US * `CLK_FREQ_KHZ + 999) / 1000)
`define START_LOW_US        50
`define START_LOW_CYC       ((`START_LOW_US * `CLK_FREQ_KHZ + 999) / 1000)
`define DATA_SETUP_US       100
`define DATA_SETUP_CYC      ((`DATA_SETUP_US * `CLK_FREQ_KHZ + 999) / 1000)
`define STOP_SETUP_US       150
`define STOP_SETUP_CYC      ((`STOP_SETUP_US * `CLK_FREQ_KHZ + 999) / 1000)
`define BREAK_LOW_US        200
`define BREAK_LOW_CYC       ((`BREAK_LOW_US * `CLK_FREQ_KHZ + 999) / 1000)
`define BREAK_REC_US        50
`define BREAK_REC_CYC       ((`BREAK_REC_US * `CLK_FREQ_KHZ + 999) / 1000)
// longest time, rounds down
`define BIT_TIMEOUT_US      250
`define BIT_TIMEOUT_CYC     ((`BIT_TIMEOUT_US * `CLK_FREQ_KHZ) / 1000)

// ****************************************
// controller register offsets (byte addresses)
// ****************************************
`define REG_CTRL            8'h00
`define REG_CMD             8'h04
`define REG_WDATA           8'h08
`define REG_RDATA           8'h0c
`define REG_STATUS          8'h10
`define REG_FLAGS           8'h14

// ctrl fields
`define CTRL_GO             0
`define CTRL_BREAK          1
`define CTRL_VERIFY         2
`define CTRL_CHG_DONE       3
// cmd fields
`define CMD_DIR             7
// status fields
`define STAT_BUSY           0
`define STAT_DONE           1
`define STAT_TIMEOUT        2
`define STAT_MISMATCH       3
`define STAT_LINE           4

// ****************************************
// device side map
// ****************************************
`define FLAGS_PRIMARY_ADDR  7'h01
`define FLG_CHARGING        7
`define FLG_PACK_REPLACED   6
`define FLG_LEARN_STALE     4
`define FLG_QUAL_DISCHARGE  3
`define FLG_FIRST_EMPTY     1

`endif

// >>> line_sync.v
// synchroniser for the single-wire line
// assumes line_i is asynchronous to clk_i
module line_sync (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire line_i,
    output wire line_s_o,
    output reg  fall_o
);

    reg meta_q;
    reg sync_q;
    reg prev_q;

    assign line_s_o = sync_q;

    // idle level of the pulled-up line is high
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
            fall_o <= 1'b0;
        end else begin
            meta_q <= line_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
            fall_o <= prev_q & ~sync_q;
        end
    end

endmodule

// >>> gauge_link_host.v
// host controller for the single-wire gauge access port
// assumes a classic wishbone master, an external pull-up on the line
//
// What this block does
// - charge-complete input held high while cells full, low otherwise.
// - line is open drain; the pull-up is external to the host.
// - every byte is eight bits, least significant bit first.
// - host never exceeds 5 kbit/s on the line.
// - after a fault such as a 250 us bit, host returns to idle and software must request a break.
// - break is a long low, then host releases the line to the pull-up for recovery.
// - each bit frame starts with the sender pulling the line low.
// - bit value valid by data setup, held for data hold.
// - line released by stop setup, high until bit cycle ends.
// - host should verify each write by reading the register back.
`include "gauge_link_defines.vh"

module gauge_link_host #(
    parameter CYCLE_CYC   = `BIT_CYCLE_CYC,
    parameter START_CYC   = `START_LOW_CYC,
    parameter SETUP_CYC   = `DATA_SETUP_CYC,
    parameter STOP_CYC    = `STOP_SETUP_CYC,
    parameter BRK_CYC     = `BREAK_LOW_CYC,
    parameter REC_CYC     = `BREAK_REC_CYC,
    parameter TIMEOUT_CYC = `BIT_TIMEOUT_CYC
) (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        line_i,
    output wire        line_o,
    output reg         line_oe_o,
    output wire        charge_complete_o
);

    // ****************************************
    // states
    // ****************************************
    localparam ST_IDLE    = 3'd0;
    localparam ST_BRK_LOW = 3'd1;
    localparam ST_BRK_REC = 3'd2;
    localparam ST_TX      = 3'd3;
    localparam ST_RX_WAIT = 3'd4;
    localparam ST_RX_BIT  = 3'd5;

    // all counts fit the 12 bit cycle counter
    localparam [11:0] CYCLE_N   = CYCLE_CYC[11:0];
    localparam [11:0] START_N   = START_CYC[11:0];
    localparam [11:0] SETUP_N   = SETUP_CYC[11:0];
    localparam [11:0] STOP_N    = STOP_CYC[11:0];
    localparam [11:0] BRK_N     = BRK_CYC[11:0];
    localparam [11:0] REC_N     = REC_CYC[11:0];
    localparam [11:0] TIMEOUT_N = TIMEOUT_CYC[11:0];

    // ****************************************
    // reset release
    // ****************************************
    reg rst_meta_q;
    reg rst_n;

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ****************************************
    // line input
    // ****************************************
    wire line_s;
    wire line_fall;

    line_sync u_sync (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n),
        .line_i   (line_i),
        .line_s_o (line_s),
        .fall_o   (line_fall)
    );

    // ****************************************
    // registers
    // ****************************************
    reg  [2:0]  state_q;
    reg  [11:0] cnt_q;
    reg  [15:0] tx_q;
    reg  [7:0]  rx_q;
    reg  [4:0]  bits_q;
    reg         write_q;
    reg         verify_pend_q;
    reg  [6:0]  addr_q;
    reg         dir_q;
    reg  [7:0]  wdata_q;
    reg  [7:0]  rdata_q;
    reg  [7:0]  flags_q;
    reg         verify_en_q;
    reg         chg_done_q;
    reg         done_q;
    reg         timeout_q;
    reg         mismatch_q;

    wire req     = wb_cyc_i & wb_stb_i;
    wire wr_en   = req & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire wr_ctrl = wr_en & (wb_adr_i == `REG_CTRL);
    wire wr_stat = wr_en & (wb_adr_i == `REG_STATUS);
    wire go_req  = wr_ctrl & wb_dat_i[`CTRL_GO];
    wire brk_req = wr_ctrl & wb_dat_i[`CTRL_BREAK];
    wire busy    = (state_q != ST_IDLE) | verify_pend_q;

    // open drain: only ever pull low, never drive high
    assign line_o            = 1'b0;
    // held level, software keeps it high while the cells stay full
    assign charge_complete_o = chg_done_q;

    // ****************************************
    // sequence end events
    // ****************************************
    wire frame_end = (cnt_q == CYCLE_N - 12'd1);
    wire tx_end    = (state_q == ST_TX) & frame_end & (bits_q == 5'd1);
    wire rx_done   = (state_q == ST_RX_BIT) & (cnt_q >= SETUP_N) & line_s;
    wire rx_end    = rx_done & (bits_q == 5'd0);
    wire brk_end   = (state_q == ST_BRK_REC) & (cnt_q == REC_N - 12'd1);
    wire waiting   = (state_q == ST_RX_WAIT) | (state_q == ST_RX_BIT);
    // a device bit longer than the limit is a fault; software must break
    wire to_hit    = waiting & ~rx_done & (cnt_q == TIMEOUT_N - 12'd1);
    wire done_set  = brk_end | (tx_end & write_q & ~verify_en_q) | rx_end;
    wire mis_set   = rx_end & verify_pend_q & (rx_q != wdata_q);

    // ****************************************
    // wishbone slave
    // ****************************************
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
            addr_q      <= 7'h00;
            dir_q       <= 1'b0;
            wdata_q     <= 8'h00;
            verify_en_q <= 1'b0;
            chg_done_q  <= 1'b0;
        end else begin
            wb_ack_o <= req & ~wb_ack_o;
            if (req & ~wb_ack_o) begin
                case (wb_adr_i)
                    `REG_CTRL:   wb_dat_o <= {28'h0000000, chg_done_q, verify_en_q, 2'b00};
                    `REG_CMD:    wb_dat_o <= {24'h000000, dir_q, addr_q};
                    `REG_WDATA:  wb_dat_o <= {24'h000000, wdata_q};
                    `REG_RDATA:  wb_dat_o <= {24'h000000, rdata_q};
                    `REG_STATUS: wb_dat_o <= {27'h0000000, line_s, mismatch_q,
                                              timeout_q, done_q, busy};
                    `REG_FLAGS:  wb_dat_o <= {24'h000000, flags_q};
                    default:     wb_dat_o <= 32'h0000_0000;
                endcase
            end
            if (wr_ctrl) begin
                verify_en_q <= wb_dat_i[`CTRL_VERIFY];
                chg_done_q  <= wb_dat_i[`CTRL_CHG_DONE];
            end
            // command fields are frozen while a transfer runs
            if (wr_en & ~busy & (wb_adr_i == `REG_CMD)) begin
                addr_q <= wb_dat_i[6:0];
                dir_q  <= wb_dat_i[`CMD_DIR];
            end
            if (wr_en & ~busy & (wb_adr_i == `REG_WDATA))
                wdata_q <= wb_dat_i[7:0];
        end
    end

    // ****************************************
    // sticky status, hardware set wins over clear
    // ****************************************
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            done_q     <= 1'b0;
            timeout_q  <= 1'b0;
            mismatch_q <= 1'b0;
        end else begin
            done_q     <= done_set | (done_q & ~(wr_stat & wb_dat_i[`STAT_DONE]));
            timeout_q  <= to_hit | (timeout_q & ~(wr_stat & wb_dat_i[`STAT_TIMEOUT]));
            mismatch_q <= mis_set | (mismatch_q & ~(wr_stat & wb_dat_i[`STAT_MISMATCH]));
        end
    end

    // ****************************************
    // line driver
    // ****************************************
    // a one bit releases after the start low, a zero holds to stop setup
    wire [11:0] low_len = tx_q[0] ? START_N : STOP_N;

    // registered, so the whole frame lags one cycle but keeps its length
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            line_oe_o <= 1'b0;
        else
            line_oe_o <= (state_q == ST_BRK_LOW) |
                         ((state_q == ST_TX) & (cnt_q < low_len));
    end

    // ****************************************
    // bit sequencer
    // ****************************************
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q       <= ST_IDLE;
            cnt_q         <= 12'h000;
            tx_q          <= 16'h0000;
            rx_q          <= 8'h00;
            bits_q        <= 5'h00;
            write_q       <= 1'b0;
            verify_pend_q <= 1'b0;
            rdata_q       <= 8'h00;
            flags_q       <= 8'h00;
        end else if (brk_req) begin
            // a break aborts whatever is in flight
            state_q       <= ST_BRK_LOW;
            cnt_q         <= 12'h000;
            verify_pend_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_q <= 12'h000;
                    if (verify_pend_q) begin
                        // read back the register just written
                        tx_q    <= {8'h00, 1'b0, addr_q};
                        bits_q  <= 5'd8;
                        write_q <= 1'b0;
                        state_q <= ST_TX;
                    end else if (go_req) begin
                        // command first, data byte after it, lsb first
                        tx_q    <= {wdata_q, dir_q, addr_q};
                        bits_q  <= dir_q ? 5'd16 : 5'd8;
                        write_q <= dir_q;
                        state_q <= ST_TX;
                    end
                end
                ST_BRK_LOW: begin
                    cnt_q <= cnt_q + 12'd1;
                    if (cnt_q == BRK_N - 12'd1) begin
                        cnt_q   <= 12'h000;
                        state_q <= ST_BRK_REC;
                    end
                end
                ST_BRK_REC: begin
                    cnt_q <= cnt_q + 12'd1;
                    if (brk_end)
                        state_q <= ST_IDLE;
                end
                ST_TX: begin
                    cnt_q <= cnt_q + 12'd1;
                    // full bit cycle per frame keeps the rate at the limit
                    if (frame_end) begin
                        cnt_q  <= 12'h000;
                        tx_q   <= {1'b0, tx_q[15:1]};
                        bits_q <= bits_q - 5'd1;
                        if (tx_end) begin
                            if (write_q) begin
                                verify_pend_q <= verify_en_q;
                                state_q       <= ST_IDLE;
                            end else begin
                                bits_q  <= 5'd8;
                                state_q <= ST_RX_WAIT;
                            end
                        end
                    end
                end
                ST_RX_WAIT: begin
                    cnt_q <= cnt_q + 12'd1;
                    if (line_fall) begin
                        cnt_q   <= 12'h000;
                        state_q <= ST_RX_BIT;
                    end else if (to_hit) begin
                        verify_pend_q <= 1'b0;
                        state_q       <= ST_IDLE;
                    end
                end
                ST_RX_BIT: begin
                    cnt_q <= cnt_q + 12'd1;
                    // the falling edge passes one register more than the sampled level line_s
                    if (cnt_q == SETUP_N - 12'd1) begin
                        rx_q   <= {line_s, rx_q[7:1]};
                        bits_q <= bits_q - 5'd1;
                    end
                    if (rx_end) begin
                        rdata_q       <= rx_q;
                        verify_pend_q <= 1'b0;
                        if (addr_q == `FLAGS_PRIMARY_ADDR)
                            flags_q <= rx_q;
                        state_q <= ST_IDLE;
                    end else if (rx_done) begin
                        cnt_q   <= 12'h000;
                        state_q <= ST_RX_WAIT;
                    end else if (to_hit) begin
                        verify_pend_q <= 1'b0;
                        state_q       <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cnt_q   <= 12'h000;
                end
            endcase
        end
    end

endmodule

// >>> gauge_link_host_asserts.sv
// concurrent checks on the ports of the gauge link host controller
// assumes it is bound into gauge_link_host and sees only its ports
`include "gauge_link_defines.vh"
module gauge_link_host_asserts #(
    parameter CYCLE_CYC = 40,
    parameter START_CYC = 10,
    parameter STOP_CYC  = 30,
    parameter BRK_CYC   = 40
) (
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        line_o,
    input wire logic        line_oe_o,
    input wire logic        charge_complete_o
);
    // ****************************************
    // helper counters
    // ****************************************
    logic [15:0] hi_q;
    logic [15:0] gap_q;
    logic [1:0]  miss_q;
    logic        prev_q;
    logic        chg_q;
    wire         req    = wb_cyc_i && wb_stb_i;
    wire         mapped = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= `REG_FLAGS);
    wire         ctl_wr = req && wb_ack_o && wb_we_i && wb_adr_i == `REG_CTRL && wb_sel_i[0];

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            hi_q <= 16'h0;
            gap_q <= 16'hffff;
            miss_q <= 2'h0;
            prev_q <= 1'b0;
            chg_q <= 1'b0;
        end else begin
            prev_q <= line_oe_o;
            hi_q <= line_oe_o ? hi_q + 16'h1 : 16'h0;
            // saturate so an idle line never looks like a short gap
            if (line_oe_o && !prev_q)
                gap_q <= 16'h1;
            else if (gap_q != 16'hffff)
                gap_q <= gap_q + 16'h1;
            if (ctl_wr)
                chg_q <= wb_dat_i[`CTRL_CHG_DONE];
            miss_q <= (charge_complete_o != chg_q) ? miss_q + 2'h1 : 2'h0;
        end
    end

    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_ack_follows: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(req))
        else $error("ack without request");
    chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_unmapped_read: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_open_drain: assert property (line_o == 1'b0)
        else $error("line data not held low");
    chk_pulse_width: assert property (!line_oe_o && prev_q |->
        (hi_q == START_CYC || hi_q == STOP_CYC || hi_q == BRK_CYC))
        else $error("line low pulse of wrong length");
    chk_frame_space: assert property (line_oe_o && !prev_q |-> gap_q >= CYCLE_CYC)
        else $error("frames closer than one bit cycle");
    chk_chg_track: assert property (miss_q <= 2'h1)
        else $error("charge complete output not following control");

    cov_break: cover property (!line_oe_o && prev_q && hi_q == BRK_CYC);
    cov_rdata: cover property (wb_ack_o && !wb_we_i && wb_adr_i == `REG_RDATA);
    cov_chg: cover property ($rose(charge_complete_o));
endmodule

bind gauge_link_host gauge_link_host_asserts #(
    .CYCLE_CYC(CYCLE_CYC), .START_CYC(START_CYC), .STOP_CYC(STOP_CYC), .BRK_CYC(BRK_CYC)
) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .line_o(line_o), .line_oe_o(line_oe_o),
    .charge_complete_o(charge_complete_o)
);

// >>> gauge_device_model.sv
// behavioural model of the gauge device on the single-wire line
// assumes line_i is the resolved wire with a pull-up; pull_o pulls it low
module gauge_device_model #(
    parameter SAMPLE_CYC = 20,
    parameter CYCLE_CYC  = 40,
    parameter BRK_CYC    = 35,
    parameter COUNT_ADDR = 9
) (
    input  wire logic  clk_i,
    input  wire logic  line_i,
    input  wire logic  charge_done_i,
    input  wire logic  mute_i,
    input  wire logic  slow_i,
    output logic       pull_o,
    output logic [7:0] cmd_o
);
    // ****************************************
    // register file and event logic
    // ****************************************
    logic [7:0] regs [0:127];
    logic [7:0] dat;
    logic       done_q;
    int         lowc;

    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
        regs[1] = 8'h54;
        pull_o = 1'b0;
        cmd_o = 8'h00;
        done_q = 1'b0;
        lowc = 0;
    end

    always @(posedge clk_i) begin
        done_q <= charge_done_i;
        // no learn and no sense input here: the count never clears, capacity never moves
        if (charge_done_i && !done_q) begin
            regs[1][3] <= 1'b1;
            // a finished charge is the only valid charge this model knows of
            if (regs[COUNT_ADDR] != 8'hff)
                regs[COUNT_ADDR] <= regs[COUNT_ADDR] + 8'h01;
            if (regs[COUNT_ADDR] == 8'h3f)
                regs[1][4] <= 1'b1;
        end
        lowc <= line_i ? 0 : lowc + 1;
        // a long low restarts the port whatever it was doing
        if (lowc == BRK_CYC)
            disable session;
    end

    // ****************************************
    // line bit engine
    // ****************************************
    task automatic rx_byte(output logic [7:0] b);
        for (int k = 0; k < 8; k++) begin
            while (!line_i) @(posedge clk_i);
            while (line_i) @(posedge clk_i);
            repeat (SAMPLE_CYC) @(posedge clk_i);
            b[k] = line_i;
        end
    endtask

    task automatic tx_byte(input logic [7:0] b);
        int w;
        repeat (CYCLE_CYC - SAMPLE_CYC) @(posedge clk_i);
        for (int k = 0; k < 8; k++) begin
            w = b[k] ? 10 : 30;
            repeat (slow_i ? 4 : 1) @(posedge clk_i);
            pull_o <= 1'b1;
            repeat (w) @(posedge clk_i);
            pull_o <= 1'b0;
            repeat (CYCLE_CYC - w) @(posedge clk_i);
        end
    endtask

    initial begin
        forever begin : session
            pull_o <= 1'b0;
            rx_byte(dat);
            cmd_o = dat;
            if (dat[7]) begin
                rx_byte(dat);
                // the primary flags are read only
                if (cmd_o[6:0] != 7'h01)
                    regs[cmd_o[6:0]] = dat;
            end else if (!mute_i) begin
                tx_byte(regs[cmd_o[6:0]]);
            end
        end
    end
endmodule

// >>> gauge_link_host_test.sv
// self-checking bench for the gauge link host controller
// assumes the device model answers on the shared pulled-up wire
`include "gauge_link_defines.vh"
module gauge_link_host_test;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // stimulus and wiring
    // ****************************************
    logic        clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  sel = 4'h0;
    logic        mute = 1'b0;
    logic        slow = 1'b0;
    logic        chg = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        oe;
    logic        chg_o;
    logic        pull;
    logic [7:0]  cmd_seen;
    wire         line_w = !(oe || pull);
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          exp_regs [0:127];

    // break and recovery keep their full lengths, so only one break is sent
    gauge_link_host #(.CYCLE_CYC(40), .START_CYC(10), .SETUP_CYC(20), .STOP_CYC(30),
        .TIMEOUT_CYC(50)) dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .line_i(line_w), .line_o(), .line_oe_o(oe), .charge_complete_o(chg_o));

    gauge_device_model u_dev (.clk_i(clk_i), .line_i(line_w), .charge_done_i(chg_o),
        .mute_i(mute), .slow_i(slow), .pull_o(pull), .cmd_o(cmd_seen));

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    // ****************************************
    // tasks
    // ****************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // ctl holds verify, break and go; the charge level rides along on every control write
    task automatic op(input logic [7:0] c, input logic [7:0] d, input logic [2:0] ctl,
                      output logic [31:0] st);
        logic [31:0] q;
        xfer(1'b1, `REG_WDATA, {24'h0, d}, 4'hf, q);
        xfer(1'b1, `REG_CMD, {24'h0, c}, 4'hf, q);
        xfer(1'b1, `REG_CTRL, {28'h0, chg, ctl}, 4'hf, q);
        st = 32'h0;
        for (int n = 0; n < 2000 && st[2:1] == 2'b00; n++)
            xfer(1'b0, `REG_STATUS, 32'h0, 4'hf, st);
        xfer(1'b1, `REG_STATUS, 32'he, 4'hf, q);
        if (ctl[0])
            check("command byte", {24'h0, cmd_seen}, ctl[2] ? {25'h0, c[6:0]} : {24'h0, c});
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            report_and_stop;
        end
    end

    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        logic [31:0] q;
        logic [31:0] st;
        logic [15:0] r;
        logic [6:0]  a;
        r = 16'h5da2;
        foreach (exp_regs[i]) exp_regs[i] = 0;
        exp_regs[1] = 32'h54;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        xfer(1'b0, `REG_CTRL, 32'h0, 4'hf, q);
        check("ctrl reset", q, 32'h0);
        xfer(1'b0, `REG_STATUS, 32'h0, 4'hf, q);
        check("status idle", q, 32'h10);
        xfer(1'b1, 8'h18, 32'hff, 4'hf, q);
        xfer(1'b0, 8'h18, 32'h0, 4'hf, q);
        check("unmapped", q, 32'h0);
        xfer(1'b1, `REG_CTRL, 32'h8, 4'h0, q);
        @(posedge clk_i);
        check("charge sel off", {31'h0, chg_o}, 32'h0);
        op(8'h01, 8'h00, 3'b001, st);
        check("read status", st, 32'h12);
        xfer(1'b0, `REG_RDATA, 32'h0, 4'hf, q);
        check("flags read", q, exp_regs[1]);
        xfer(1'b0, `REG_FLAGS, 32'h0, 4'hf, q);
        check("flags copy", q, exp_regs[1]);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            a = (r[6:0] < 7'h2) ? 7'h2 : r[6:0];
            slow <= r[7];
            op({1'b1, a}, r[15:8], 3'b101, st);
            check("verified write", st, 32'h12);
            exp_regs[a] = r[15:8];
            op({1'b0, a}, 8'h00, 3'b001, st);
            xfer(1'b0, `REG_RDATA, 32'h0, 4'hf, q);
            check("read back", q, exp_regs[a]);
        end
        op(8'h81, 8'h00, 3'b101, st);
        check("read only flags", st, 32'h1a);
        chg = 1'b1;
        xfer(1'b1, `REG_CTRL, 32'h8, 4'hf, q);
        @(posedge clk_i);
        check("charge level", {31'h0, chg_o}, 32'h1);
        exp_regs[1] = exp_regs[1] | 32'h8;
        op(8'h01, 8'h00, 3'b001, st);
        xfer(1'b0, `REG_RDATA, 32'h0, 4'hf, q);
        check("qualified flag", q, exp_regs[1]);
        exp_regs[9] = (exp_regs[9] == 255) ? 255 : exp_regs[9] + 1;
        op(8'h09, 8'h00, 3'b001, st);
        xfer(1'b0, `REG_RDATA, 32'h0, 4'hf, q);
        check("charge count", q, exp_regs[9]);
        mute <= 1'b1;
        op(8'h02, 8'h00, 3'b001, st);
        check("timeout", st, 32'h14);
        mute <= 1'b0;
        op(8'h00, 8'h00, 3'b010, st);
        check("break done", st, 32'h12);
        op(8'h01, 8'h00, 3'b001, st);
        xfer(1'b0, `REG_RDATA, 32'h0, 4'hf, q);
        check("after break", q, exp_regs[1]);
        report_and_stop;
    end
endmodule
